// ### src/ddr2_col_defines.svh
// Constants for the column access and burst transfer block.
//
// Overview of operation
// R1: CS low, others high: no operation.
// R2: CS high: command decoder ignores all.
// R3: 1024-column page, 4- or 8-column segments.
// R4: Burst stays inside its aligned segment.
// R5: Controller interrupts only BL8, same direction.
// R6: Controller spaces column commands two clocks.
// R7: Posted command held for additive latency.
// R8: Read latency is additive plus CAS.
// R9: Write latency is read latency minus one.
// R10: Early column commands need nonzero additive latency.
// R11: Burst length four or eight; type bit.
// R12: Sequential order wraps within nibble groups.
// R13: Interleaved order is start XOR beat.
// R14: No burst stop command exists.
// R15: Strobe driven low one clock early.
// R16: First read beat on rising strobe.
// R17: Latencies come from mode register inputs.
// R18: Controller sends write preamble then data.
// R19: Capture full burst, ignore later data.
// R20: Controller waits write recovery before precharge.
// R21: Back-to-back bursts with no idle cycles.
// R22: Read decode: bank, column, auto-precharge bit.
// R23: Write decode same, write enable low.
// R24: Controller idles bus with no-operation.
// R25: Two beats per clock, rise then fall.
`ifndef DDR2_COL_DEFINES_SVH
`define DDR2_COL_DEFINES_SVH

// -----------------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------------
`define DDR_COL_W 10
`define DDR_BANK_W 3
`define DDR_ADDR_PIN_W 14
`define DDR_AP_BIT 10
`define DDR_DQ_W 8

// -----------------------------------------------------------------------------
// Mode settings and depths
// -----------------------------------------------------------------------------
`define DDR_BL4_CODE 3'h2
`define DDR_BL8_CODE 3'h3
`define DDR_PIPE_D 16
`define DDR_WQ_D 4
`define DDR_MIN_RL 4'h2

`endif

// ### src/ddr2_col_pkg.sv
// Types and the burst ordering function shared by the column access block.
package ddr2_col_pkg;

    // Decoded command class of one clock.
    typedef enum logic [1:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_OTHER} cmd_e;

    // One decoded command with its address fields.
    typedef struct packed {
        cmd_e kind;
        logic [2:0] bank;
        logic [9:0] col;
        logic ap;
    } cmd_s;

    // Captured write pairs: two halves of four {rise, fall} pairs.
    typedef logic [1:0][3:0][15:0] wbuf_t;

    // Low three column bits of a given beat of a burst.
    function automatic logic [2:0] beat_low(input logic [2:0] start, input logic [2:0] beat,
                                            input logic bl8, input logic il);
        logic [2:0] r;
        r = '0;
        if (il) begin
            r = bl8 ? (start ^ beat) : {start[2], start[1:0] ^ beat[1:0]}; // R13
        end else begin
            r[1:0] = start[1:0] + beat[1:0]; // R12
            r[2] = bl8 ? (start[2] ^ beat[2]) : start[2]; // R4
        end
        return r;
    endfunction : beat_low

endpackage : ddr2_col_pkg

// ### src/wr_link_if.sv
// Carrier between the system-clock core and the strobe-clock write capture.
`timescale 1ns/1ps
`default_nettype none
interface wr_link_if;
    import ddr2_col_pkg::*;
    logic bl8; // Burst length eight selected, system side level.
    logic done_tgl; // Toggles once per completed write burst.
    wbuf_t words; // Captured pairs, stable while their half is idle.
    modport sys(output bl8, input done_tgl, input words);
    modport link(input bl8, output done_tgl, output words);
endinterface : wr_link_if
`default_nettype wire

// ### src/cmd_decode.sv
// Command decoder for the column access block.
`timescale 1ns/1ps
`default_nettype none
module cmd_decode
    import ddr2_col_pkg::*;
(
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    output cmd_s cmd
);
    `include "ddr2_col_defines.svh"

    // -------------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------------
    // Classifies the pins; there is no burst stop code, so it falls in OTHER.
    always_comb begin
        cmd.kind = CMD_NOP;
        cmd.bank = ba;
        cmd.col = addr[`DDR_COL_W-1:0]; // R22
        cmd.ap = addr[`DDR_AP_BIT];
        if (cs_n) begin
            cmd.kind = CMD_NOP; // R2
        end else if (ras_n && cas_n && we_n) begin
            cmd.kind = CMD_NOP; // R1
        end else if (ras_n && !cas_n && we_n) begin
            cmd.kind = CMD_READ; // R22
        end else if (ras_n && !cas_n && !we_n) begin
            cmd.kind = CMD_WRITE; // R23
        end else begin
            cmd.kind = CMD_OTHER; // R14
        end
    end
endmodule : cmd_decode
`default_nettype wire

// ### src/write_capture.sv
// Write data capture running on the controller's write strobe clock.
`timescale 1ns/1ps
`default_nettype none
module write_capture
    import ddr2_col_pkg::*;
(
    input wire logic dqs_clk,
    input wire logic sys_rst,
    input wire logic [7:0] dq_in_rise,
    input wire logic [7:0] dq_in_fall,
    wr_link_if.link lk
);
    // All state of the capture side.
    typedef struct packed {
        logic [1:0] cnt; // Pair index within the running burst.
        logic side; // Half of the buffer being filled.
        logic done_tgl; // Event toward the system clock.
        wbuf_t words; // Double buffer of captured pairs.
    } cap_s;

    cap_s q;
    cap_s n;

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    // The strobe runs only during write bursts, so every rising edge is a
    // pair; a burst ends by its own count, not by any later edge.
    // The length setting is read as a quasi-static level: the strobe stands
    // still between bursts, so a strobe-clocked synchroniser would lag one
    // whole burst behind a change; the setting may change only when idle.
    always_comb begin
        n = q;
        n.words[q.side][q.cnt] = {dq_in_rise, dq_in_fall}; // R25
        if (q.cnt == (lk.bl8 ? 2'h3 : 2'h1)) begin
            // Burst complete: hand the half over and switch halves.
            n.cnt = 2'h0; // R19
            n.side = ~q.side;
            n.done_tgl = ~q.done_tgl;
        end else begin
            n.cnt = q.cnt + 2'h1;
        end
    end

    // Registers the capture state.
    always_ff @(posedge dqs_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign lk.done_tgl = q.done_tgl;
    assign lk.words = q.words;
endmodule : write_capture
`default_nettype wire

// ### src/ddr2_column_burst_access.sv
// Column access, posted commands and burst data paths of a DDR2 memory.
`timescale 1ns/1ps
`default_nettype none
module ddr2_column_burst_access
    import ddr2_col_pkg::*;
#(
    parameter int COL_W = 10, // Column bits of a page.
    parameter int BANK_W = 3, // Bank bits.
    parameter int PIPE_D = 16, // Longest supported read latency.
    parameter int WQ_D = 4 // Writes that may wait for their data.
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic dqs_clk,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic [2:0] cas_lat,
    input wire logic [2:0] add_lat,
    input wire logic [2:0] burst_len,
    input wire logic burst_il,
    input wire logic [7:0] dq_in_rise,
    input wire logic [7:0] dq_in_fall,
    output logic [7:0] dq_out_rise,
    output logic [7:0] dq_out_fall,
    output logic dq_oe,
    output logic dqs_out,
    output logic dqs_oe,
    output logic wr_pending,
    output logic bl_illegal
);
    `include "ddr2_col_defines.svh"

    // -------------------------------------------------------------------------
    // Local types
    // -------------------------------------------------------------------------
    localparam int MEM_D = 2 ** (BANK_W + COL_W); // Bytes held.
    localparam int QW = $clog2(WQ_D); // Queue pointer width.

    // A write waiting for its data from the strobe domain.
    typedef struct packed {
        logic [2:0] bank;
        logic [9:0] col;
        logic bl8;
    } wq_s;

    // All state of the system-clock side.
    typedef struct packed {
        cmd_s [PIPE_D-1:0] pipe; // Posted command delay line.
        logic [2:0] rd_left; // Data cycles still to follow.
        logic [2:0] rd_beat; // Next beat number of the read.
        logic [2:0] rd_bank; // Bank of the running read.
        logic [9:0] rd_col; // Start column of the running read.
        logic rd_bl8; // Length of the running read.
        logic [7:0] dq_r; // Beat sent with the rising strobe.
        logic [7:0] dq_f; // Beat sent with the falling strobe.
        logic dq_oe; // Data pins driven.
        logic dqs; // Strobe level: high in data cycles.
        logic dqs_oe; // Strobe driven.
        logic bl8; // Registered length setting.
        logic bl_bad; // Length code not four or eight.
        wq_s [WQ_D-1:0] wq; // Pending writes.
        logic [QW-1:0] wp; // Queue write pointer.
        logic [QW-1:0] rp; // Queue read pointer.
        logic [QW:0] wcnt; // Queue fill.
        logic done_s1; // First synchroniser stage.
        logic done_s2; // Second stage.
        logic done_s3; // Edge reference.
        logic rd_side; // Buffer half to copy next.
        logic [MEM_D-1:0][7:0] mem; // Array contents.
    } st_s;

    st_s q;
    st_s n;
    cmd_s cmd_now;
    wr_link_if lk();

    // Forms the array index of one beat of a burst.
    function automatic logic [BANK_W+COL_W-1:0] beat_addr(input logic [2:0] bank,
                                                          input logic [9:0] col,
                                                          input logic [2:0] beat,
                                                          input logic bl8,
                                                          input logic il);
        logic [2:0] low;
        low = beat_low(col[2:0], beat, bl8, il);
        return {bank[BANK_W-1:0], col[COL_W-1:3], low}; // R3
    endfunction : beat_addr

    // -------------------------------------------------------------------------
    // Submodules
    // -------------------------------------------------------------------------
    // Pin decode of the current clock.
    cmd_decode u_dec (
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .ba(ba),
        .addr(addr),
        .cmd(cmd_now)
    );

    // Write capture on the strobe clock.
    write_capture u_cap (
        .dqs_clk(dqs_clk),
        .sys_rst(sys_rst),
        .dq_in_rise(dq_in_rise),
        .dq_in_fall(dq_in_fall),
        .lk(lk)
    );

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    // One combinational pass: command delay, read engine, write queue and
    // the commit of captured write data into the array.
    always_comb begin
        logic [3:0] rl;
        logic lat_ok;
        logic bl8_cfg;
        cmd_s rd_slot;
        cmd_s pre_slot;
        logic load;
        logic active;
        logic [2:0] beat;
        logic [2:0] bank;
        logic [9:0] col;
        logic bl8;
        logic push;
        logic pop;
        logic done_ev;
        wq_s head;
        logic [7:0] byte_v;
        beat = 3'h0;
        bank = 3'h0;
        col = 10'h000;
        byte_v = 8'h00;
        rl = {1'b0, add_lat} + {1'b0, cas_lat}; // R8 R17
        lat_ok = rl >= `DDR_MIN_RL;
        bl8_cfg = burst_len == `DDR_BL8_CODE; // R11
        n = q;
        n.bl8 = bl8_cfg;
        n.bl_bad = (burst_len != `DDR_BL4_CODE) && !bl8_cfg; // R11

        // Commands march through the delay line; any may be posted.
        n.pipe = {q.pipe[PIPE_D-2:0], cmd_now}; // R7
        rd_slot = q.pipe[rl - 4'h1];
        pre_slot = q.pipe[rl - 4'h2];

        // A read leaves the line after RL edges and starts its data.
        load = lat_ok && (rd_slot.kind == CMD_READ); // R8
        active = load || (q.rd_left != 3'h0);
        if (load) begin
            // A new read replaces any unfinished one at once.
            beat = 3'h0; // R21
            bank = rd_slot.bank;
            col = rd_slot.col;
            bl8 = bl8_cfg;
        end else begin
            beat = q.rd_beat;
            bank = q.rd_bank;
            col = q.rd_col;
            bl8 = q.rd_bl8;
        end
        if (load) begin
            // Remaining data cycles after this one.
            n.rd_left = bl8_cfg ? 3'h3 : 3'h1; // R25
        end else if (q.rd_left != 3'h0) begin
            n.rd_left = q.rd_left - 3'h1;
        end else begin
            n.rd_left = 3'h0;
        end
        n.rd_beat = beat + 3'h2;
        n.rd_bank = bank;
        n.rd_col = col;
        n.rd_bl8 = bl8;
        if (active) begin
            // Even beat rides the rising strobe, odd beat the falling one.
            n.dq_r = q.mem[beat_addr(bank, col, beat, bl8, burst_il)]; // R16
            n.dq_f = q.mem[beat_addr(bank, col, beat + 3'h1, bl8, burst_il)]; // R25
        end else begin
            n.dq_r = 8'h00;
            n.dq_f = 8'h00;
        end
        n.dq_oe = active;
        n.dqs = active; // R16
        // Strobe is driven low the clock before the first data.
        n.dqs_oe = active || (lat_ok && (pre_slot.kind == CMD_READ)); // R15

        // A write is queued at its write latency, one before the read slot.
        push = lat_ok && (pre_slot.kind == CMD_WRITE)
               && (q.wcnt != (QW+1)'(WQ_D)); // R9
        head = q.wq[q.rp];

        // Completion events cross from the strobe clock as a toggle.
        n.done_s1 = lk.done_tgl;
        n.done_s2 = q.done_s1;
        n.done_s3 = q.done_s2;
        done_ev = q.done_s2 != q.done_s3;
        pop = done_ev && (q.wcnt != '0);
        if (done_ev) begin
            n.rd_side = ~q.rd_side;
        end
        if (pop) begin
            // Commit only the beats of the burst; stale pairs past a four-beat burst are skipped.
            for (int b = 0; b < 8; b++) begin
                byte_v = (b % 2 == 0) ? lk.words[q.rd_side][b / 2][15:8]
                                      : lk.words[q.rd_side][b / 2][7:0];
                if (head.bl8 || (b < 4)) begin
                    n.mem[beat_addr(head.bank, head.col, 3'(b), head.bl8, burst_il)] =
                        byte_v; // R19
                end
            end
            n.rp = q.rp + QW'(1);
        end
        if (push) begin
            n.wq[q.wp] = '{bank: pre_slot.bank, col: pre_slot.col, bl8: bl8_cfg};
            n.wp = q.wp + QW'(1);
        end
        n.wcnt = q.wcnt + (QW+1)'(push) - (QW+1)'(pop);
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    // Registers the whole system-side state.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign lk.bl8 = q.bl8;
    assign dq_out_rise = q.dq_r;
    assign dq_out_fall = q.dq_f;
    assign dq_oe = q.dq_oe;
    assign dqs_out = q.dqs;
    assign dqs_oe = q.dqs_oe;
    assign wr_pending = q.wcnt != '0;
    assign bl_illegal = q.bl_bad;
endmodule : ddr2_column_burst_access
`default_nettype wire

// ### bench/ddr2_col_asserts.sv
// Port-level timing checks for the column burst block.
`timescale 1ns/1ps
`default_nettype none
module ddr2_col_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] cas_lat,
    input wire logic [2:0] add_lat,
    input wire logic [2:0] burst_len,
    input wire logic dq_oe,
    input wire logic dqs_out,
    input wire logic dqs_oe,
    input wire logic wr_pending,
    input wire logic bl_illegal
);
    // ------------------------------------------------------------
    // Command history
    // ------------------------------------------------------------
    logic [15:0] rd_q; // Bit n is set n edges after a taken read.
    logic [15:0] wr_q; // Bit n is set n edges after a taken write.
    logic [3:0] rl; // Read latency formed from both latency settings.
    logic col_cmd; // A column command is on the pins.
    logic bl_ok; // The burst length code is supported.
    assign rl = {1'b0, add_lat} + {1'b0, cas_lat};
    assign col_cmd = !cs_n && ras_n && !cas_n;
    assign bl_ok = burst_len == 3'h2 || burst_len == 3'h3;
    // Shifts the command history so every latency is a plain bit index.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_q <= '0;
            wr_q <= '0;
        end else begin
            rd_q <= {rd_q[14:0], col_cmd && we_n};
            wr_q <= {wr_q[14:0], col_cmd && !we_n};
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_rd_preamble: assert property (rd_q[rl - 4'h1] && !dq_oe |-> dqs_oe && !dqs_out)
        else $error("Strobe preamble missing before read data.");
    a_rd_first_pair: assert property (rd_q[rl] |-> dq_oe && dqs_oe && dqs_out)
        else $error("First read pair not at read latency.");
    a_rd_second_pair: assert property (rd_q[rl + 4'h1] |-> dq_oe)
        else $error("Read burst ended after one pair.");
    a_bl8_tail: assert property (burst_len == 3'h3 && rd_q[rl + 4'h3] |-> dq_oe)
        else $error("Eight beat read burst cut short.");
    a_quiet_bus: assert property (rd_q == 16'h0000 |-> !dq_oe && !dqs_oe)
        else $error("Data driven with no read taken.");
    a_strobe_with_data: assert property (dq_oe |-> dqs_oe && dqs_out)
        else $error("Read data without strobe high phase.");
    a_wr_queued: assert property (wr_q[rl - 4'h1] |-> wr_pending)
        else $error("Write not queued at write latency.");
    a_wr_not_early: assert property (wr_q[rl - 4'h2] |-> !wr_pending)
        else $error("Write queued before write latency.");
    a_bl_good: assert property (bl_ok [*5] |-> !bl_illegal)
        else $error("Supported burst length flagged.");
    a_bl_bad: assert property (!bl_ok [*5] |-> bl_illegal)
        else $error("Unsupported burst length not flagged.");
endmodule : ddr2_col_asserts
bind ddr2_column_burst_access ddr2_col_asserts u_chk (.clk_sys, .sys_rst, .cs_n, .ras_n, .cas_n,
    .we_n, .cas_lat, .add_lat, .burst_len, .dq_oe, .dqs_out, .dqs_oe, .wr_pending, .bl_illegal);
`default_nettype wire

// ### bench/wr_strobe_source.sv
// Controller model that sends write strobe bursts with data pairs.
`timescale 1ns/1ps
`default_nettype none
module wr_strobe_source (
    input wire logic go,
    input wire logic bl8,
    input wire logic [63:0] beats,
    output logic dqs_clk,
    output logic [7:0] dq_rise,
    output logic [7:0] dq_fall
);
    // Each rise of go sends one burst, strobe low first as the preamble.
    initial begin
        dqs_clk = 1'b0;
        dq_rise = 8'h00;
        dq_fall = 8'hFF;
        forever begin
            @(posedge go);
            for (int k = 0; k < (bl8 ? 4 : 2); k++) begin
                dq_rise = beats[16 * k +: 8];
                dq_fall = beats[16 * k + 8 +: 8];
                #12 dqs_clk = 1'b1;
                #24 dqs_clk = 1'b0;
                #12;
            end
            // Released rails show the inverse so stale data cannot pass.
            dq_rise = ~dq_rise;
            dq_fall = ~dq_fall;
        end
    end
endmodule : wr_strobe_source
`default_nettype wire

// ### bench/tb_ddr2_column_burst_access.sv
// Self-checking bench for the column burst block.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_column_burst_access;
    logic clk_sys = 1'b0;
    logic sys_rst, cs_n, ras_n, cas_n, we_n, burst_il, go, cfg_bl8, dqs_clk;
    logic [2:0] ba, cas_lat, add_lat, burst_len;
    logic [13:0] addr;
    logic [7:0] dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall;
    logic dq_oe, dqs_out, dqs_oe, wr_pending, bl_illegal;
    logic [63:0] beats; // Write burst, beat n in byte n.
    logic [7:0] mem [0:7][0:1023]; // Expected array contents.
    logic [15:0] exp_q [$]; // Expected read pairs, oldest first.
    logic [31:0] seed = 32'h5746;
    int bad_count = 0;
    int comparisons = 0;
    // Free-running system clock.
    always #10 clk_sys = ~clk_sys;
    ddr2_column_burst_access DUT (.clk_sys, .sys_rst, .dqs_clk, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .cas_lat, .add_lat, .burst_len, .burst_il, .dq_in_rise, .dq_in_fall, .dq_out_rise,
        .dq_out_fall, .dq_oe, .dqs_out, .dqs_oe, .wr_pending, .bl_illegal);
    wr_strobe_source ctl (.go, .bl8(cfg_bl8), .beats, .dqs_clk, .dq_rise(dq_in_rise),
        .dq_fall(dq_in_fall));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Column of beat k inside the aligned segment of start column c.
    function automatic logic [9:0] cidx(input logic [9:0] c, input int k);
        logic [2:0] s = c[2:0];
        logic [2:0] b = k[2:0];
        if (burst_il) return {c[9:3], cfg_bl8 ? s ^ b : {s[2], s[1:0] ^ b[1:0]}};
        return {c[9:3], cfg_bl8 ? s[2] ^ b[2] : s[2], s[1:0] + b[1:0]};
    endfunction : cidx
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Drives {cs, ras, cas, we}, bank and address for one clock.
    task automatic put(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(posedge clk_sys);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
    endtask : put
    // Idle clocks carry no-operations or deselects with random pins.
    task automatic idle(input int n);
        logic [31:0] r;
        repeat (n) begin
            r = rnd();
            put(r[20] ? 4'h7 : {1'b1, r[2:0]}, r[5:3], r[19:6]);
        end
    endtask : idle
    // Column command; a write fills the model, a read queues its pairs.
    task automatic col_cmd(input logic wr, input logic [2:0] b, input logic [9:0] c);
        logic [31:0] r;
        r = rnd();
        put({3'b010, ~wr}, b, {r[3:0], c});
        for (int k = 0; k < (cfg_bl8 ? 8 : 4); k += 2) begin
            if (wr) begin
                mem[b][cidx(c, k)] = beats[8 * k +: 8];
                mem[b][cidx(c, k + 1)] = beats[8 * k + 8 +: 8];
            end else begin
                exp_q.push_back({mem[b][cidx(c, k)], mem[b][cidx(c, k + 1)]});
            end
        end
    endtask : col_cmd
    // One write, then two seamless reads from other starts in its segment.
    task automatic trial();
        logic [31:0] r;
        logic [9:0] c;
        int rl;
        r = rnd();
        c = r[18:9];
        rl = r[3:2] + r[5:4] + 2;
        cfg_bl8 = r[0];
        beats = {rnd(), rnd()};
        @(posedge clk_sys);
        burst_len <= r[0] ? 3'h3 : 3'h2;
        burst_il <= r[1];
        add_lat <= {1'b0, r[3:2]};
        cas_lat <= 3'h2 + {1'b0, r[5:4]};
        idle(6);
        col_cmd(1'b1, r[8:6], c);
        idle(rl);
        go <= 1'b1;
        idle(1);
        for (int n = 0; n < 60 && wr_pending !== 1'b0; n++) idle(1);
        check({15'h0000, wr_pending}, 16'h0000);
        go <= 1'b0;
        c[1:0] = r[20:19];
        if (cfg_bl8) c[2] = r[21];
        col_cmd(1'b0, r[8:6], c);
        idle(cfg_bl8 ? 3 : 1);
        c[1:0] = ~c[1:0];
        col_cmd(1'b0, r[8:6], c);
        idle(20);
        $display("Trial done: bl8 %0d interleaved %0d latency %0d", cfg_bl8, burst_il, rl);
    endtask : trial
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Each read pair on the outputs is checked against the oldest note.
    always @(posedge clk_sys) begin
        if (dq_oe === 1'b1) begin
            check({dq_out_rise, dq_out_fall}, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
        end
    end
    // Watchdog cuts a hang short.
    initial begin
        #200000;
        bad_count++;
        $display("[ERR] %0t run did not finish", $time);
        summarize();
    end
    // Main sequence.
    initial begin
        {sys_rst, cs_n, ras_n, cas_n, we_n, burst_il, go, cfg_bl8} = 8'hF8;
        {ba, addr, cas_lat, add_lat, burst_len, beats} = {17'h00000, 9'h0D2, 64'h0};
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        burst_len <= 3'h5;
        idle(8);
        check({15'h0000, bl_illegal}, 16'h0001);
        repeat (12) trial();
        check(16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule : tb_ddr2_column_burst_access
`default_nettype wire
